// ==== hw/epr_core.sv ====
// Purpose: Command logic of a serial EEPROM seen from its SPI pins.
// Assumes: Mode 0 master; pins are asynchronous to clk and are synchronised here.
// Notes: srst models power-up; guard and lock bits keep their value across it.
`timescale 1ns/1ns
module epr_core import epr_pkg::*; #(
  parameter int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // SPI link from the master.
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  // Serial output with its enable.
  output logic miso,
  output logic miso_oe
);

  // ----------------------------------------
  // State and helper signals
  // ----------------------------------------
  localparam logic [TMR_W-1:0] ERASE_AT = TMR_W'(PROG_CYCLES / 2);

  // Registered state; it starts all zero, with lock and guard bits cleared like every other field.
  epr_st_type q = '0;
  epr_st_type d; // Next state.
  logic [7:0] mem [0:ARRAY_BYTES-1] = '{default: DELIVERY_BYTE}; // Array, delivered with every bit high.
  logic [7:0] pbuf [0:PAGE_BYTES-1]; // Page buffer for a write.
  logic sck_rise, sck_fall, cs_rise, cs_fall; // Link edges.
  logic [7:0] sh_byte; // Byte completed by this shift.
  logic [ADDR_W-1:0] ld_addr; // Address from the low address byte.
  logic [ADDR_W-1:0] nxt_addr; // Next read address.
  logic pb_we; // Page buffer write strobe.
  logic rd_step, wr_step, opc_bad; // Event marks.
  logic prog_end, erase_now; // Program cycle phases.
  logic hard_guard; // Status locked by lock bit and pin.

  assign sck_rise = q.sck_sy[1] & ~q.sck_sy[2];
  assign sck_fall = ~q.sck_sy[1] & q.sck_sy[2];
  assign cs_rise = q.cs_sy[1] & ~q.cs_sy[2];
  assign cs_fall = ~q.cs_sy[1] & q.cs_sy[2];
  assign sh_byte = {q.sh[6:0], q.mosi_sy[1]};
  assign ld_addr = {q.addr[ADDR_W-1:8], sh_byte};
  assign nxt_addr = q.addr + ADDR_W'(1);
  assign hard_guard = q.nv[2] & ~q.wp_sy[1];
  assign miso = q.miso;
  assign miso_oe = q.miso_oe;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // One pass computes synchronisers, program timer, deselect handling and shifting.
  always_comb begin
    d = q;
    pb_we = 1'b0;
    rd_step = 1'b0;
    wr_step = 1'b0;
    opc_bad = 1'b0;
    prog_end = 1'b0;
    erase_now = 1'b0;
    // First stages feed only the second stages.
    d.sck_sy = {q.sck_sy[1:0], sck};
    d.cs_sy = {q.cs_sy[1:0], cs_n};
    d.mosi_sy = {q.mosi_sy[0], mosi};
    d.wp_sy = {q.wp_sy[0], wp_n};
    // Self-timed cycle: erase at half time, program and release at the end.
    if (q.busy) begin
      d.timer = q.timer - TMR_W'(1);
      erase_now = (q.timer == ERASE_AT);
      if (q.timer == TMR_W'(1)) begin
        prog_end = 1'b1;
        d.busy = 1'b0;
        d.modify_enable_latch = 1'b0;
        if (q.kind_status) begin
          d.nv = q.pend;
        end
      end
    end
    if (cs_rise) begin
      // Deselect ends every command, a read at any point included.
      d.state = S_IDLE;
      d.miso_oe = 1'b0;
      if (q.bitcnt == 3'h0) begin
        case (q.state)
          S_WAIT: begin
            if (q.opc == OPC_MODIFY_ENABLE) begin
              d.modify_enable_latch = 1'b1;
            end else if (q.opc == OPC_MODIFY_DISABLE) begin
              d.modify_enable_latch = 1'b0;
            end
          end
          S_SDATA: begin
            // Exactly one byte, latch set, idle, and not hard guarded.
            if (q.nbytes == 2'h1 && q.modify_enable_latch && !q.busy && !hard_guard) begin
              d.busy = 1'b1;
              d.kind_status = 1'b1;
              d.timer = TMR_W'(PROG_CYCLES);
            end
          end
          S_WDATA: begin
            // At least one byte, latch set, idle and page not guarded.
            if (q.nbytes != 2'h0 && q.modify_enable_latch && !q.busy && !epr_guarded(q.addr, q.nv[1:0])) begin
              d.busy = 1'b1;
              d.kind_status = 1'b0;
              d.timer = TMR_W'(PROG_CYCLES);
            end
          end
          default: begin
          end
        endcase
      end
    end else if (cs_fall) begin
      // A falling select edge is needed before any command.
      d.state = S_OPC;
      d.bitcnt = 3'h0;
      d.nbytes = 2'h0;
    end else if (q.state != S_IDLE && q.state != S_IGNORE) begin
      if (sck_rise) begin
        d.sh = sh_byte;
        d.bitcnt = q.bitcnt + 3'h1;
        if (q.bitcnt == 3'h7) begin
          case (q.state)
            S_OPC: begin
              d.opc = sh_byte;
              case (sh_byte)
                OPC_READ, OPC_WRITE: d.state = q.busy ? S_IGNORE : S_ADDR;
                OPC_STATUS_WRITE: d.state = q.busy ? S_IGNORE : S_SDATA;
                OPC_MODIFY_ENABLE, OPC_MODIFY_DISABLE: d.state = S_WAIT;
                OPC_STATUS_READ: begin
                  d.state = S_RSTAT;
                  d.out = epr_status(q.nv, q.modify_enable_latch, q.busy);
                  d.obit = 3'h0;
                  d.miso_oe = 1'b1;
                end
                default: begin
                  // Unknown opcode: stop listening until the next select.
                  opc_bad = 1'b1;
                  d.state = S_IGNORE;
                end
              endcase
            end
            S_ADDR: begin
              if (q.nbytes == 2'h0) begin
                // Upper address bits beyond the array are dropped.
                d.addr = {sh_byte[ADDR_W-9:0], q.addr[7:0]};
                d.nbytes = 2'h1;
              end else begin
                d.addr = ld_addr;
                d.nbytes = 2'h0;
                d.mask = '0;
                if (q.opc == OPC_READ) begin
                  d.state = S_RDATA;
                  d.out = mem[ld_addr];
                  d.obit = 3'h0;
                  d.miso_oe = 1'b1;
                end else begin
                  d.state = S_WDATA;
                end
              end
            end
            S_SDATA: begin
              // Only lock and guard bits are captured.
              d.pend = {sh_byte[STAT_LOCK], sh_byte[STAT_GUARD_HI], sh_byte[STAT_GUARD_LO]};
              if (q.nbytes != 2'h3) begin
                d.nbytes = q.nbytes + 2'h1;
              end
            end
            S_WDATA: begin
              // Buffer the byte and step only the in-page address bits.
              pb_we = 1'b1;
              wr_step = 1'b1;
              d.mask = q.mask | (PAGE_BYTES'(1) << q.addr[PAGE_W-1:0]);
              d.addr[PAGE_W-1:0] = q.addr[PAGE_W-1:0] + PAGE_W'(1);
              if (q.nbytes != 2'h3) begin
                d.nbytes = q.nbytes + 2'h1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      if (sck_fall && (q.state == S_RDATA || q.state == S_RSTAT)) begin
        // Output changes on the falling edge so the master samples on rising.
        d.miso = q.out[7];
        d.out = {q.out[6:0], 1'b0};
        d.obit = q.obit + 3'h1;
        if (q.obit == 3'h7) begin
          if (q.state == S_RDATA) begin
            rd_step = 1'b1;
            d.addr = nxt_addr;
            d.out = mem[nxt_addr];
          end else begin
            d.out = epr_status(q.nv, q.modify_enable_latch, q.busy);
          end
        end
      end
    end
    // Power-up: everything idle, but the non-volatile bits are kept.
    if (srst) begin
      d = '0;
      d.nv = q.nv;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // State register; every field comes from the next-state pass.
  always_ff @(posedge clk) begin
    q <= d;
  end

  // Page buffer and array: erase the buffered bytes, then program them.
  always_ff @(posedge clk) begin
    if (pb_we) begin
      pbuf[q.addr[PAGE_W-1:0]] <= sh_byte;
    end
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (q.mask[i] && !q.kind_status) begin
        if (erase_now) begin
          mem[{q.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= ERASED_BYTE;
        end else if (prog_end) begin
          mem[{q.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_busy_len: assert property (@(posedge clk) disable iff (srst) $rose(q.busy) |-> q.busy[*8])
    else $error("busy did not hold for the cycle");
  a_busy_end: assert property (@(posedge clk) disable iff (srst)
    (q.busy && q.timer == TMR_W'(1)) |=> (!q.busy && !q.modify_enable_latch))
    else $error("cycle end did not clear busy and latch");
  a_nv_late: assert property (@(posedge clk) disable iff (srst)
    (q.nv != $past(q.nv)) |-> ($past(q.busy) && !q.busy))
    else $error("guard bits changed outside cycle end");
  a_hard_lock: assert property (@(posedge clk) disable iff (srst)
    ($rose(q.busy) && q.kind_status) |-> ($past(q.modify_enable_latch) && !$past(hard_guard)))
    else $error("status write accepted while locked");
  a_write_ok: assert property (@(posedge clk) disable iff (srst)
    ($rose(q.busy) && !q.kind_status) |-> ($past(q.modify_enable_latch) && !epr_guarded(q.addr, q.nv[1:0])))
    else $error("array write accepted against guard");
  a_read_idle: assert property (@(posedge clk) disable iff (srst)
    (q.state == S_RDATA) |-> !q.busy)
    else $error("read running during program cycle");
  a_read_wrap: assert property (@(posedge clk) disable iff (srst)
    (rd_step && q.addr == {ADDR_W{1'b1}}) |=> (q.addr == '0))
    else $error("read address did not wrap to zero");
  a_page_roll: assert property (@(posedge clk) disable iff (srst)
    wr_step |=> (q.addr[ADDR_W-1:PAGE_W] == $past(q.addr[ADDR_W-1:PAGE_W])))
    else $error("write address left its page");
  a_opc_bad: assert property (@(posedge clk) disable iff (srst)
    opc_bad |=> (q.state == S_IGNORE && !q.miso_oe)[*2])
    else $error("unknown opcode did not deselect");

  // Deselect and power-up: commands end, outputs fall silent, guard bits stay.
  a_cs_end: assert property (@(posedge clk) disable iff (srst)
    cs_rise |=> (q.state == S_IDLE && !q.miso_oe))
    else $error("deselect did not end the command");
  a_reset_idle: assert property (@(posedge clk)
    srst |=> (q.state == S_IDLE && !q.busy && !q.modify_enable_latch && !q.miso_oe && !q.miso))
    else $error("power-up state not idle");
  a_nv_keep: assert property (@(posedge clk)
    srst |=> (q.nv == $past(q.nv)))
    else $error("power-up changed guard or lock bits");

  // Status write acceptance and its delayed effect.
  a_sw_align: assert property (@(posedge clk) disable iff (srst)
    (cs_rise && q.state == S_SDATA && q.bitcnt != 3'h0 && !q.busy) |=> !q.busy)
    else $error("misaligned status write started a cycle");
  a_soft_open: assert property (@(posedge clk) disable iff (srst)
    (cs_rise && q.state == S_SDATA && q.bitcnt == 3'h0 && q.nbytes == 2'h1 && q.modify_enable_latch && !q.busy && !q.nv[2])
    |=> (q.busy && q.kind_status))
    else $error("unlocked status write was refused");
  a_nv_apply: assert property (@(posedge clk) disable iff (srst)
    (prog_end && q.kind_status) |=> (q.nv == $past(q.pend)))
    else $error("status cycle did not apply the new bits");

  // Array write refusal and read data path.
  a_wr_align: assert property (@(posedge clk) disable iff (srst)
    (cs_rise && q.state == S_WDATA && q.bitcnt != 3'h0 && !q.busy) |=> !q.busy)
    else $error("misaligned array write started a cycle");
  a_busy_cmd: assert property (@(posedge clk) disable iff (srst)
    (!cs_rise && !cs_fall && sck_rise && q.state == S_OPC && q.bitcnt == 3'h7 && q.busy
    && (sh_byte == OPC_READ || sh_byte == OPC_WRITE || sh_byte == OPC_STATUS_WRITE))
    |=> (q.state == S_IGNORE && !q.miso_oe))
    else $error("command taken during program cycle");
  a_rd_load: assert property (@(posedge clk) disable iff (srst)
    (!cs_rise && !cs_fall && sck_rise && q.state == S_ADDR && q.bitcnt == 3'h7 && q.nbytes == 2'h1
    && q.opc == OPC_READ) |=> (q.state == S_RDATA && q.miso_oe && q.out == mem[q.addr]))
    else $error("read did not load the addressed byte");
  a_rd_step: assert property (@(posedge clk) disable iff (srst)
    rd_step |=> (q.out == mem[q.addr]))
    else $error("read did not step to the next byte");
  a_oe_read: assert property (@(posedge clk) disable iff (srst)
    q.miso_oe |-> (q.state == S_RDATA || q.state == S_RSTAT))
    else $error("serial out driven outside a read");

endmodule : epr_core

// ==== shared/epr_pkg.sv ====
// Purpose: Constants, types and helpers for the serial EEPROM command logic.
// Assumes: An SPI mode 0 master; the system clock oversamples the shift clock.
// Notes: The status byte is {lock, 0, 0, 0, guard_size_hi, guard_size_lo, latch, busy}.
package epr_pkg;

  // ----------------------------------------
  // Command opcodes
  // ----------------------------------------
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_MODIFY_DISABLE = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;
  localparam logic [7:0] OPC_MODIFY_ENABLE = 8'h06;

  // ----------------------------------------
  // Array geometry and guard ranges
  // ----------------------------------------
  localparam int ADDR_W = 11;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int ARRAY_BYTES = 2048;
  localparam logic [10:0] GUARD_QUARTER_BASE = 11'h600;
  localparam logic [10:0] GUARD_HALF_BASE = 11'h400;
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [7:0] DELIVERY_BYTE = 8'hFF;

  // ----------------------------------------
  // Status bit positions and timing
  // ----------------------------------------
  localparam int STAT_LOCK = 7;
  localparam int STAT_GUARD_HI = 3;
  localparam int STAT_GUARD_LO = 2;
  localparam int unsigned PROG_TIME_NS = 5000000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int TMR_W = 17;

  // Command sequencer states.
  typedef enum logic [3:0] {
    S_IDLE, S_OPC, S_ADDR, S_RDATA, S_RSTAT, S_SDATA, S_WDATA, S_WAIT, S_IGNORE
  } epr_state_type;

  // Whole state of the device; nv is {lock, guard_size_hi, guard_size_lo}.
  typedef struct packed {
    logic [2:0] sck_sy;
    logic [2:0] cs_sy;
    logic [1:0] mosi_sy;
    logic [1:0] wp_sy;
    epr_state_type state;
    logic [2:0] bitcnt;
    logic [2:0] obit;
    logic [7:0] sh;
    logic [7:0] out;
    logic [7:0] opc;
    logic [ADDR_W-1:0] addr;
    logic [1:0] nbytes;
    logic [PAGE_BYTES-1:0] mask;
    logic busy;
    logic modify_enable_latch;
    logic kind_status;
    logic [2:0] pend;
    logic [2:0] nv;
    logic [TMR_W-1:0] timer;
    logic miso;
    logic miso_oe;
  } epr_st_type;

  // Builds the status byte; bits 6 to 4 always read as zero.
  function automatic logic [7:0] epr_status(input logic [2:0] nv, input logic modify_enable_latch, input logic busy);
    epr_status = {nv[2], 3'h0, nv[1:0], modify_enable_latch, busy};
  endfunction : epr_status

  // True when the page holding addr lies in the guarded range.
  function automatic logic epr_guarded(input logic [ADDR_W-1:0] addr, input logic [1:0] guard);
    logic [ADDR_W-1:0] base;
    base = {addr[ADDR_W-1:PAGE_W], PAGE_W'(0)};
    case (guard)
      GUARD_NONE: epr_guarded = 1'b0;
      GUARD_QUARTER: epr_guarded = (base >= GUARD_QUARTER_BASE);
      GUARD_HALF: epr_guarded = (base >= GUARD_HALF_BASE);
      default: epr_guarded = 1'b1;
    endcase
  endfunction : epr_guarded

endpackage : epr_pkg

// ==== verif/epr_core_bench.sv ====
// Purpose: Self-checking bench of the EEPROM command logic.
// Assumes: A short program cycle so the run stays brief.
// Notes: Results are judged through status reads and array reads.
`timescale 1ns/1ns
module epr_core_bench import epr_pkg::*;;
  logic clk, srst, wp_n, sck, cs_n, mosi, miso, miso_oe, miso_w, last_q, oe_seen;
  logic [7:0] st;
  logic [7:0] r[$];
  int fail_count = 0;
  int total_checks = 0;
  // A released serial out shows the inverse of its last level.
  assign miso_w = miso_oe ? miso : ~last_q;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (miso_oe) begin
      last_q <= miso;
      oe_seen <= 1'b1;
    end
  end

  epr_core #(.PROG_CYCLES(1000)) epr_core_inst (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n),
    .mosi(mosi), .wp_n(wp_n), .miso(miso), .miso_oe(miso_oe));
  epr_spi_master epr_spi_master_inst (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso_w(miso_w));

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic fr(input logic [7:0] b[$], input int t = 0);
    epr_spi_master_inst.frame(b, t, r);
  endtask : fr

  task automatic stchk(input logic [7:0] e);
    fr({OPC_STATUS_READ, 8'h00});
    st = r[1];
    check(st, e);
  endtask : stchk

  // Polls busy under a bounded count.
  task automatic wait_idle();
    for (int i = 0; i < 20; i++) begin
      fr({OPC_STATUS_READ, 8'h00});
      st = r[1];
      if (st[0] === 1'b0) return;
    end
    fail_count++;
    $display("[FAIL] t=%0t busy stuck %h %h", $time, st, 8'h00);
    finish_test();
  endtask : wait_idle

  task automatic modify_enable_cmd();
    fr({OPC_MODIFY_ENABLE});
  endtask : modify_enable_cmd

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    modify_enable_cmd();
    fr({OPC_WRITE, a[15:8], a[7:0], d});
  endtask : wr

  task automatic wsr(input logic [7:0] d);
    modify_enable_cmd();
    fr({OPC_STATUS_WRITE, d});
  endtask : wsr

  task automatic rdchk(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    fr({OPC_READ, a[15:8], a[7:0], 8'h00, 8'h00});
    check(r[3], e0);
    check(r[4], e1);
  endtask : rdchk

  task automatic t_page();
    stchk(8'h00);
    modify_enable_cmd();
    fr({OPC_WRITE, 8'h00, 8'h1E, 8'hA1, 8'hB2, 8'hC3});
    oe_seen <= 1'b0;
    fr({OPC_READ, 8'h00, 8'h1E, 8'h00});
    check({7'h0, oe_seen}, 8'h00);
    stchk(8'h03);
    wait_idle();
    stchk(8'h00);
    rdchk(16'h001E, 8'hA1, 8'hB2);
    rdchk(16'h0000, 8'hC3, 8'hFF);
    wr(16'hFFFF, 8'h5A);
    wait_idle();
    rdchk(16'hF7FF, 8'h5A, 8'hC3);
    $display("done page and wrap");
  endtask : t_page

  task automatic t_refuse();
    fr({OPC_WRITE, 8'h00, 8'h40, 8'h11});
    fr({OPC_STATUS_WRITE, 8'h8C});
    stchk(8'h00);
    modify_enable_cmd();
    fr({OPC_WRITE, 8'h00, 8'h40, 8'h11}, 3);
    fr({OPC_STATUS_WRITE, 8'h8C}, 2);
    stchk(8'h02);
    rdchk(16'h0040, 8'hFF, 8'hFF);
    oe_seen <= 1'b0;
    fr({8'hFF, OPC_READ, 8'h00});
    check({7'h0, oe_seen}, 8'h00);
    oe_seen <= 1'b0;
    fr({OPC_READ, 8'h00, 8'h00}, 4);
    check({7'h0, oe_seen}, 8'h01);
    check({7'h0, miso_oe}, 8'h00);
    fr({OPC_MODIFY_DISABLE});
    stchk(8'h00);
    $display("done refusals");
  endtask : t_refuse

  // Each guard code against probes in the second, third and upper quarters.
  task automatic t_guard();
    logic [15:0] pa[3] = '{16'h03E0, 16'h05E0, 16'h07E0};
    logic [7:0] ex[3] = '{8'hFF, 8'hFF, 8'hFF};
    logic [7:0] d;
    for (int g = 0; g < 4; g++) begin
      wsr({4'h7, g[1:0], 2'h3});
      wait_idle();
      stchk({4'h0, g[1:0], 2'h0});
      for (int p = 0; p < 3; p++) begin
        d = {g[3:0], 2'h0, p[1:0]};
        wr(pa[p], d);
        wait_idle();
        if (g + p < 3) ex[p] = d;
        rdchk(pa[p], ex[p], 8'hFF);
      end
    end
    $display("done guard codes");
  endtask : t_guard

  task automatic t_lock();
    wsr(8'h8C);
    wait_idle();
    stchk(8'h8C);
    wp_n <= 1'b0;
    wsr(8'h00);
    stchk(8'h8E);
    wp_n <= 1'b1;
    wsr(8'h00);
    stchk(8'h8F);
    wait_idle();
    stchk(8'h00);
    wp_n <= 1'b0;
    wsr(8'h80);
    wait_idle();
    stchk(8'h80);
    wsr(8'h00);
    stchk(8'h82);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    stchk(8'h80);
    wp_n <= 1'b1;
    wsr(8'h00);
    wait_idle();
    stchk(8'h00);
    $display("done lock");
  endtask : t_lock

  initial begin
    srst = 1'b1;
    wp_n = 1'b1;
    last_q = 1'b0;
    oe_seen = 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_page();
    t_refuse();
    t_guard();
    t_lock();
    finish_test();
  end
endmodule : epr_core_bench

// ==== verif/epr_spi_master.sv ====
// Purpose: Behavioural SPI mode 0 master that drives the EEPROM pins.
// Assumes: A 400 ns shift clock made from eight clk periods.
// Notes: The shift clock rests low and data in toggles while deselected.
`timescale 1ns/1ns
module epr_spi_master (
  // Sampling clock.
  input wire logic clk,
  // Link towards the device.
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso_w
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Shifts n bits MSB first; data is set while sck is low and read after the rise.
  task automatic shift(input logic [7:0] v, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      mosi <= v[7-i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      rx = {rx[6:0], miso_w};
      repeat (2) @(posedge clk);
    end
  endtask : shift

  // One whole frame: whole bytes, then tail extra bits to break the boundary.
  task automatic frame(input logic [7:0] b[$], input int tail, output logic [7:0] r[$]);
    logic [7:0] x;
    r = {};
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (b[i]) begin
      shift(b[i], 8, x);
      r.push_back(x);
    end
    shift(8'hA5, tail, x);
    // Deselect after the last rise and before any further rise.
    sck <= 1'b0;
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : epr_spi_master
